// ---- bcwl_loader.sv ----
// configuration window loader: window, start-up load, otp and eeprom copies
// Behaviour
// - page 0 holds 128-bit id from otp, loaded at each on, host-locked
// - page 1 factory data from otp at each on, host cannot change
// - pages 2 and 3 load bootstrap data at on, source picked by device
// - page 4 marker copied only when bootstrap comes from eeprom
// - otp holds four pages mapping to window pages 0 to 3
// - eeprom holds three word pages mapping to window pages 2, 3, 4
// - eeprom big-endian bytes: even byte high, odd low, byte 0 at page 2
// - window words read and written by host in off, on, sleep
// - host reaches eeprom and otp only through window copies
// - window pages 2 and 3 programmed into otp only in program state
// - paths: eeprom to window, window to otp, otp to window; none back
// - window contents reflected out to functional register locations
// - secondary serial clock pin high at start-up selects eeprom source
// - eeprom absent or marker not A596h keeps device off
// - zero customer id field keeps device off on every start path
// - reload bit clear skips pages 2 to 4, pages 0 and 1 still load
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bcwl_loader
  import bcwl_pkg::*;
(
  input  wire logic                              ref_clk_i,
  input  wire logic                              sys_rst_i,
  input  wire logic [bcwl_pkg::ADDR_W-1:0]       bus_addr_i,
  input  wire logic [bcwl_pkg::WORD_W-1:0]       bus_wdata_i,
  input  wire logic                              bus_we_i,
  input  wire logic                              bus_re_i,
  output logic      [bcwl_pkg::WORD_W-1:0]       bus_rdata_o,
  input  wire bcwl_pkg::bcwl_pwr_t               power_state_i,
  input  wire logic                              on_request_i,
  output logic                                   start_ok_o,
  output logic                                   start_fail_o,
  input  wire logic                              secondary_serial_clock_pin_i,
  output logic                                   otp_req_o,
  output logic                                   otp_we_o,
  output logic      [bcwl_pkg::IDX_W-2:0]        otp_addr_o,
  output logic      [bcwl_pkg::WORD_W-1:0]       otp_wdata_o,
  input  wire logic [bcwl_pkg::WORD_W-1:0]       otp_rdata_i,
  input  wire logic                              otp_ack_i,
  output logic                                   ee_req_o,
  output logic      [bcwl_pkg::EE_ADDR_W-1:0]    ee_addr_o,
  input  wire logic [7:0]                        ee_data_i,
  input  wire logic                              ee_ack_i,
  input  wire logic                              ee_nack_i,
  output logic      [bcwl_pkg::WIN_WORDS*bcwl_pkg::WORD_W-1:0] config_window_o
);
  import bcwl_pkg::*;

  bcwl_state_t       st_ff;
  logic [WORD_W-1:0] win_ff [WIN_WORDS];
  logic [IDX_W-1:0]  idx_ff;
  logic [IDX_W-1:0]  end_ff;
  logic [IDX_W-1:0]  ee_byte_ff;
  logic [7:0]        hi_ff;
  logic              boot_ff;
  logic              to_ee_ff;
  logic              dev_ff;
  logic              reload_ff;
  logic              ee_fail_ff;
  logic              id_fail_ff;
  logic              boot_ok_ff;
  logic              refused_ff;
  logic              start_ok_ff;
  logic              start_fail_ff;
  logic [WORD_W-1:0] rdata_ff;
  logic              pin_sync;
  logic              idle;
  logic              win_hit;
  logic              host_wr;
  logic              cmd_wr;
  logic              wr_otp_ok;
  logic              otp_done;
  logic              ee_done;
  logic              check_id_bad;
  logic              check_ee_bad;
  logic [IDX_W-1:0]  ee_word;
  logic [WORD_W-1:0] status;

  bcwl_sync u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (secondary_serial_clock_pin_i),
    .sync_o    (pin_sync)
  );

  assign idle     = (st_ff == S_IDLE);
  assign win_hit  = (bus_addr_i < ADDR_W'(WIN_WORDS));
  // pages 0 and 1 never accept host data; busy window is closed to the host
  assign host_wr  = bus_we_i && win_hit && idle && !on_request_i &&
                    (bus_addr_i >= ADDR_W'(PAGE2_BASE));
  assign cmd_wr   = bus_we_i && (bus_addr_i == REG_CTRL) && idle && !on_request_i;
  assign wr_otp_ok = (power_state_i == PWR_PROGRAM);
  assign otp_done = otp_ack_i && (idx_ff == end_ff);
  assign ee_done  = ee_ack_i && (ee_byte_ff == EE_LAST_BYTE);
  assign ee_word  = PAGE2_BASE + {1'b0, ee_byte_ff[IDX_W-1:1]};
  assign check_id_bad = (win_ff[CUST_ID_IDX] == '0);
  assign check_ee_bad = dev_ff && (ee_fail_ff || win_ff[MARKER_IDX] != MARKER_VALUE);

  // sequencer: start-up load and host commands
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_ff      <= S_IDLE;
      idx_ff     <= '0;
      end_ff     <= '0;
      ee_byte_ff <= '0;
      boot_ff    <= 1'b0;
      to_ee_ff   <= 1'b0;
    end else begin
      unique case (st_ff)
        S_IDLE: begin
          if (on_request_i) begin
            // pages 0 and 1 always; 2 and 3 from otp only without eeprom
            idx_ff     <= PAGE0_BASE;
            end_ff     <= (reload_ff && !pin_sync) ? PAGE3_LAST : PAGE1_LAST;
            to_ee_ff   <= reload_ff && pin_sync;
            ee_byte_ff <= '0;
            boot_ff    <= 1'b1;
            st_ff      <= S_OTP;
          end else if (cmd_wr && bus_wdata_i[CTRL_RD_OTP]) begin
            idx_ff   <= PAGE0_BASE;
            end_ff   <= PAGE3_LAST;
            to_ee_ff <= 1'b0;
            boot_ff  <= 1'b0;
            st_ff    <= S_OTP;
          end else if (cmd_wr && bus_wdata_i[CTRL_RD_EE]) begin
            ee_byte_ff <= '0;
            boot_ff    <= 1'b0;
            st_ff      <= S_EE;
          end else if (cmd_wr && bus_wdata_i[CTRL_WR_OTP] && wr_otp_ok) begin
            idx_ff  <= PAGE2_BASE;
            end_ff  <= PAGE3_LAST;
            boot_ff <= 1'b0;
            st_ff   <= S_WR;
          end
        end
        S_OTP: begin
          if (otp_ack_i) begin
            idx_ff <= idx_ff + 1'b1;
            if (otp_done) begin
              st_ff <= to_ee_ff ? S_EE : (boot_ff ? S_CHECK : S_IDLE);
            end
          end
        end
        S_EE: begin
          if (ee_nack_i) begin
            st_ff <= boot_ff ? S_CHECK : S_IDLE;
          end else if (ee_ack_i) begin
            ee_byte_ff <= ee_byte_ff + 1'b1;
            if (ee_done) begin
              st_ff <= boot_ff ? S_CHECK : S_IDLE;
            end
          end
        end
        S_WR: begin
          if (otp_ack_i) begin
            idx_ff <= idx_ff + 1'b1;
            if (otp_done) begin
              st_ff <= S_IDLE;
            end
          end
        end
        S_CHECK: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

  // window storage: host writes and loads share one write port
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < WIN_WORDS; i++) begin
        win_ff[i] <= '0;
      end
    end else if (st_ff == S_OTP && otp_ack_i) begin
      win_ff[idx_ff] <= otp_rdata_i;
    end else if (st_ff == S_EE && ee_ack_i && ee_byte_ff[0] &&
                 (boot_ff || ee_word < PAGE4_BASE)) begin
      // word lands at page 2 plus half the byte address; marker page only at start-up
      win_ff[ee_word] <= {hi_ff, ee_data_i};
    end else if (host_wr) begin
      win_ff[bus_addr_i[IDX_W-1:0]] <= bus_wdata_i;
    end
  end

  // even byte held until its odd partner arrives
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      hi_ff <= '0;
    end else if (st_ff == S_EE && ee_ack_i && !ee_byte_ff[0]) begin
      hi_ff <= ee_data_i;
    end
  end

  // control bits and start-up outcome
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reload_ff     <= CTRL_RELOAD_RST;
      dev_ff        <= 1'b0;
      ee_fail_ff    <= 1'b0;
      id_fail_ff    <= 1'b0;
      boot_ok_ff    <= 1'b0;
      refused_ff    <= 1'b0;
      start_ok_ff   <= 1'b0;
      start_fail_ff <= 1'b0;
    end else begin
      start_ok_ff   <= 1'b0;
      start_fail_ff <= 1'b0;
      if (cmd_wr) begin
        reload_ff  <= bus_wdata_i[CTRL_RELOAD];
        refused_ff <= bus_wdata_i[CTRL_WR_OTP] && !wr_otp_ok;
      end
      if (idle && on_request_i) begin
        // the pin is sampled once per start-up, not followed afterwards
        dev_ff     <= pin_sync;
        ee_fail_ff <= 1'b0;
        id_fail_ff <= 1'b0;
        boot_ok_ff <= 1'b0;
      end
      if (st_ff == S_EE && ee_nack_i) begin
        ee_fail_ff <= 1'b1;
      end
      if (st_ff == S_CHECK) begin
        id_fail_ff    <= check_id_bad;
        boot_ok_ff    <= !check_id_bad && !check_ee_bad;
        start_ok_ff   <= !check_id_bad && !check_ee_bad;
        start_fail_ff <= check_id_bad || check_ee_bad;
        if (check_ee_bad) begin
          ee_fail_ff <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    status               = '0;
    status[STAT_BUSY]    = !idle;
    status[STAT_DEV]     = dev_ff;
    status[STAT_EE_FAIL] = ee_fail_ff;
    status[STAT_ID_FAIL] = id_fail_ff;
    status[STAT_BOOT_OK] = boot_ok_ff;
    status[STAT_REFUSED] = refused_ff;
  end

  // read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
    end else if (bus_re_i) begin
      if (win_hit) begin
        rdata_ff <= win_ff[bus_addr_i[IDX_W-1:0]];
      end else if (bus_addr_i == REG_CTRL) begin
        rdata_ff <= {{(WORD_W-1){1'b0}}, reload_ff};
      end else if (bus_addr_i == REG_STATUS) begin
        rdata_ff <= status;
      end else begin
        rdata_ff <= '0;
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  // memory ports hold request until acknowledged; no eeprom write path
  assign otp_req_o   = (st_ff == S_OTP) || (st_ff == S_WR);
  assign otp_we_o    = (st_ff == S_WR);
  assign otp_addr_o  = idx_ff[IDX_W-2:0];
  assign otp_wdata_o = win_ff[idx_ff];
  assign ee_req_o    = (st_ff == S_EE);
  assign ee_addr_o   = {2'b00, ee_byte_ff};
  assign bus_rdata_o = rdata_ff;
  assign start_ok_o  = start_ok_ff;
  assign start_fail_o = start_fail_ff;

  for (genvar g = 0; g < WIN_WORDS; g++) begin : g_reflect
    assign config_window_o[g*WORD_W +: WORD_W] = win_ff[g];
  end

  page_lock_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (bus_we_i && idle && !on_request_i && bus_addr_i < ADDR_W'(PAGE2_BASE))
    |=> $stable(config_window_o))
    else $error("host write changed a locked page");

  read_latency_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (bus_re_i && bus_addr_i == REG_STATUS) |=> (bus_rdata_o == $past(status)))
    else $error("status read data not one cycle later");

  otp_prog_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    otp_we_o |-> (idx_ff >= PAGE2_BASE && idx_ff <= PAGE3_LAST))
    else $error("otp programming outside pages 2 and 3");

  prog_guard_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (cmd_wr && bus_wdata_i[CTRL_WR_OTP] && !bus_wdata_i[CTRL_RD_OTP] &&
     !bus_wdata_i[CTRL_RD_EE] && power_state_i != PWR_PROGRAM)
    |=> (st_ff == S_IDLE) && refused_ff)
    else $error("otp programming started outside program state");

  ee_order_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ee_req_o && ee_ack_i && !ee_nack_i && !ee_done)
    |=> ee_req_o && (ee_addr_o == $past(ee_addr_o) + 8'h01))
    else $error("eeprom bytes not fetched in order");

  ee_pair_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ee_req_o && ee_ack_i && !ee_byte_ff[0] && (boot_ff || ee_word < PAGE4_BASE))
    ##2 (ee_req_o && ee_ack_i && !ee_nack_i)
    |=> (win_ff[$past(ee_word)] == {$past(ee_data_i, 3), $past(ee_data_i)}))
    else $error("eeprom word not assembled high byte first");

  skip_reload_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (idle && on_request_i && !reload_ff) |=> (end_ff == PAGE1_LAST) && !to_ee_ff)
    else $error("pages 2 to 4 reloaded with reload bit clear");

  id_check_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_ff == S_CHECK && check_id_bad) |=> start_fail_o && !start_ok_o)
    else $error("zero customer id did not keep device off");

  marker_check_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_ff == S_CHECK && dev_ff && win_ff[MARKER_IDX] != MARKER_VALUE)
    |=> start_fail_o ##1 !start_fail_o)
    else $error("bad eeprom marker did not keep device off");

endmodule

// ---- bcwl_mem_model.sv ----
// behavioural otp array and byte-wide boot eeprom facing the loader
`timescale 1ns/1ps
module bcwl_mem_model
  import bcwl_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        slow_i,
  input  wire logic        ee_present_i,
  input  wire logic        otp_req_i,
  input  wire logic        otp_we_i,
  input  wire logic [4:0]  otp_addr_i,
  input  wire logic [15:0] otp_wdata_i,
  output logic      [15:0] otp_rdata_o,
  output logic             otp_ack_o,
  input  wire logic        ee_req_i,
  input  wire logic [7:0]  ee_addr_i,
  output logic      [7:0]  ee_data_o,
  output logic             ee_ack_o,
  output logic             ee_nack_o
);
  logic [15:0] otp_mem [32];
  logic [7:0]  ee_mem [48];
  logic [1:0]  wait_ff;
  // no write port toward the eeprom at all
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      otp_ack_o <= 1'b0;
      ee_ack_o  <= 1'b0;
      ee_nack_o <= 1'b0;
      wait_ff   <= 2'h0;
      otp_rdata_o <= 16'h0000;
      ee_data_o <= 8'h00;
    end else begin
      otp_ack_o <= 1'b0;
      ee_ack_o  <= 1'b0;
      ee_nack_o <= 1'b0;
      // released data lines toggle so stale values never look valid
      if (!otp_ack_o) otp_rdata_o <= ~otp_rdata_o;
      if (!ee_ack_o) ee_data_o <= ~ee_data_o;
      if ((otp_req_i && !otp_ack_o) || (ee_req_i && !ee_ack_o && !ee_nack_o)) begin
        if (slow_i && wait_ff != 2'h2) begin
          wait_ff <= wait_ff + 2'h1;
        end else begin
          wait_ff <= 2'h0;
          if (otp_req_i) begin
            otp_ack_o <= 1'b1;
            if (otp_we_i) otp_mem[otp_addr_i] <= otp_wdata_i;
            else otp_rdata_o <= otp_mem[otp_addr_i];
          end else if (!ee_present_i) begin
            ee_nack_o <= 1'b1;
          end else begin
            ee_ack_o  <= 1'b1;
            ee_data_o <= ee_mem[ee_addr_i];
          end
        end
      end
    end
  end
endmodule

// ---- bcwl_pkg.sv ----
// constants and types shared by the configuration window loader
package bcwl_pkg;

  localparam int WORD_W     = 16;
  localparam int PAGE_WORDS = 8;
  localparam int PAGES      = 5;
  localparam int WIN_WORDS  = PAGES * PAGE_WORDS;
  localparam int ADDR_W     = 7;
  localparam int IDX_W      = 6;
  localparam int EE_ADDR_W  = 8;

  // window word indices
  localparam logic [IDX_W-1:0] PAGE0_BASE  = 6'h00;
  localparam logic [IDX_W-1:0] PAGE1_LAST  = 6'h0F;
  localparam logic [IDX_W-1:0] PAGE2_BASE  = 6'h10;
  localparam logic [IDX_W-1:0] PAGE3_LAST  = 6'h1F;
  localparam logic [IDX_W-1:0] PAGE4_BASE  = 6'h20;
  localparam logic [IDX_W-1:0] CUST_ID_IDX = 6'h1F;
  localparam logic [IDX_W-1:0] MARKER_IDX  = 6'h20;

  // eeprom image: 24 words, 48 bytes, big-endian
  localparam logic [IDX_W-1:0] EE_LAST_BYTE = 6'h2F;

  localparam logic [WORD_W-1:0] MARKER_VALUE = 16'hA596;

  // register port addresses beyond the window words
  localparam logic [ADDR_W-1:0] REG_CTRL   = 7'h40;
  localparam logic [ADDR_W-1:0] REG_STATUS = 7'h41;

  // control register fields
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_RD_OTP = 1;
  localparam int CTRL_RD_EE  = 2;
  localparam int CTRL_WR_OTP = 3;
  localparam logic CTRL_RELOAD_RST = 1'b1;

  // status register fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DEV     = 1;
  localparam int STAT_EE_FAIL = 2;
  localparam int STAT_ID_FAIL = 3;
  localparam int STAT_BOOT_OK = 4;
  localparam int STAT_REFUSED = 5;

  // power state encoding
  typedef logic [1:0] bcwl_pwr_t;
  localparam bcwl_pwr_t PWR_OFF     = 2'h0;
  localparam bcwl_pwr_t PWR_ON      = 2'h1;
  localparam bcwl_pwr_t PWR_SLEEP   = 2'h2;
  localparam bcwl_pwr_t PWR_PROGRAM = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE,
    S_OTP,
    S_EE,
    S_WR,
    S_CHECK
  } bcwl_state_t;

endpackage

// ---- bcwl_sync.sv ----
// two-stage synchroniser for a level from a pin
`timescale 1ns/1ps
module bcwl_sync (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// ---- tb_bcwl_loader.sv ----
// self-checking bench for the configuration window loader
`timescale 1ns/1ps
module tb_bcwl_loader;
  import bcwl_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [6:0]        addr = 7'h00;
  logic [15:0]       wdata = 16'h0000;
  logic [15:0]       rdata;
  logic              we = 1'b0, re = 1'b0, onr = 1'b0, pin = 1'b0, slow = 1'b0, ee_on = 1'b1;
  bcwl_pwr_t         pwr = PWR_OFF;
  logic              ok, fail, otp_req, otp_we, otp_ack, ee_req, ee_ack, ee_nack;
  logic [4:0]        otp_addr;
  logic [15:0]       otp_wdata, otp_rdata;
  logic [7:0]        ee_addr, ee_data;
  logic [639:0]      win;
  int                miscompares = 0, checks_done = 0, cycles = 0;

  bcwl_loader u_bcwl_loader (.ref_clk_i(clk), .sys_rst_i(rst), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_we_i(we), .bus_re_i(re), .bus_rdata_o(rdata),
    .power_state_i(pwr), .on_request_i(onr), .start_ok_o(ok), .start_fail_o(fail),
    .secondary_serial_clock_pin_i(pin), .otp_req_o(otp_req), .otp_we_o(otp_we),
    .otp_addr_o(otp_addr), .otp_wdata_o(otp_wdata), .otp_rdata_i(otp_rdata),
    .otp_ack_i(otp_ack), .ee_req_o(ee_req), .ee_addr_o(ee_addr), .ee_data_i(ee_data),
    .ee_ack_i(ee_ack), .ee_nack_i(ee_nack), .config_window_o(win));
  bcwl_mem_model u_bcwl_mem_model (.ref_clk_i(clk), .sys_rst_i(rst), .slow_i(slow),
    .ee_present_i(ee_on), .otp_req_i(otp_req), .otp_we_i(otp_we), .otp_addr_i(otp_addr),
    .otp_wdata_i(otp_wdata), .otp_rdata_o(otp_rdata), .otp_ack_o(otp_ack),
    .ee_req_i(ee_req), .ee_addr_i(ee_addr), .ee_data_o(ee_data), .ee_ack_o(ee_ack),
    .ee_nack_o(ee_nack));

  always #50 clk = ~clk;
  // a stuck handshake would otherwise hang the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] ov(int i);
    return 16'h1100 + 16'(i);
  endfunction
  function automatic logic [7:0] eb(int b);
    return (b == 32) ? 8'hA5 : (b == 33) ? 8'h96 : 8'h30 + 8'(b);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic boot(input logic p, input logic e_ok);
    int n;
    @(posedge clk);
    pin <= p;
    repeat (3) @(posedge clk);
    onr <= 1'b1;
    @(posedge clk);
    onr <= 1'b0;
    n = 0;
    while (ok !== 1'b1 && fail !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk({14'h0, fail, ok}, {14'h0, !e_ok, e_ok});
  endtask
  task automatic drain(input logic use_ee);
    int n;
    n = 0;
    while ((use_ee ? ee_req : otp_req) !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    while ((use_ee ? ee_req : otp_req) === 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic t_reset;
    rd(REG_CTRL, 16'h0001);
    rd(REG_STATUS, 16'h0000);
    rd(7'h50, 16'h0000);
    chk(win[16*16+:16], 16'h0000);
  endtask
  task automatic t_otp_boot;
    slow = 1'b1;
    boot(1'b0, 1'b1);
    slow = 1'b0;
    for (int g = 0; g < 32; g++) chk(win[g*16+:16], ov(g));
    chk(win[32*16+:16], 16'h0000);
    rd(7'h1F, ov(31));
    rd(REG_STATUS, 16'h0010);
  endtask
  task automatic t_lock;
    wr(7'h00, 16'hDEAD);
    wr(7'h0F, 16'hBEEF);
    rd(7'h00, ov(0));
    rd(7'h0F, ov(15));
    wr(7'h10, 16'h5A5A);
    rd(7'h10, 16'h5A5A);
    @(posedge clk) pwr <= PWR_SLEEP;
    wr(7'h14, 16'h0F0F);
    rd(7'h14, 16'h0F0F);
    @(posedge clk) pwr <= PWR_OFF;
  endtask
  task automatic t_no_reload;
    wr(REG_CTRL, 16'h0000);
    wr(7'h10, 16'h1234);
    u_bcwl_mem_model.otp_mem[0] = 16'hC3C3;
    boot(1'b0, 1'b1);
    chk(win[16*16+:16], 16'h1234);
    chk(win[0+:16], 16'hC3C3);
    wr(REG_CTRL, 16'h0001);
  endtask
  task automatic t_ee_boot;
    boot(1'b1, 1'b1);
    for (int k = 0; k < 24; k++) chk(win[(16+k)*16+:16], {eb(2*k), eb(2*k+1)});
    chk(win[32*16+:16], MARKER_VALUE);
    rd(REG_STATUS, 16'h0012);
    u_bcwl_mem_model.ee_mem[33] = 8'h97;
    boot(1'b1, 1'b0);
    rd(REG_STATUS, 16'h0006);
    u_bcwl_mem_model.ee_mem[33] = 8'h96;
    ee_on = 1'b0;
    boot(1'b1, 1'b0);
    ee_on = 1'b1;
  endtask
  task automatic t_id_zero;
    u_bcwl_mem_model.otp_mem[31] = 16'h0000;
    boot(1'b0, 1'b0);
    rd(REG_STATUS, 16'h0008);
    u_bcwl_mem_model.otp_mem[31] = ov(31);
  endtask
  task automatic t_prog;
    wr(7'h10, 16'hC0DE);
    wr(REG_CTRL, 16'h0009);
    rd(REG_STATUS, 16'h0028);
    chk(u_bcwl_mem_model.otp_mem[16], ov(16));
    @(posedge clk) pwr <= PWR_PROGRAM;
    wr(REG_CTRL, 16'h0009);
    drain(1'b0);
    chk(u_bcwl_mem_model.otp_mem[16], 16'hC0DE);
    chk(u_bcwl_mem_model.otp_mem[17], ov(17));
    chk(u_bcwl_mem_model.otp_mem[0], 16'hC3C3);
    @(posedge clk) pwr <= PWR_OFF;
  endtask
  // host commands: otp into window, then eeprom into window without the marker page
  task automatic t_cmds;
    wr(7'h10, 16'h0000);
    wr(REG_CTRL, 16'h0003);
    drain(1'b0);
    chk(win[16*16+:16], 16'hC0DE);
    wr(7'h20, 16'h1234);
    wr(REG_CTRL, 16'h0005);
    drain(1'b1);
    chk(win[16*16+:16], 16'h3031);
    chk(win[32*16+:16], 16'h1234);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 32; i++) u_bcwl_mem_model.otp_mem[i] = ov(i);
    for (int b = 0; b < 48; b++) u_bcwl_mem_model.ee_mem[b] = eb(b);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_otp_boot();
    t_lock();
    t_no_reload();
    t_ee_boot();
    t_id_zero();
    t_prog();
    t_cmds();
    report_and_stop();
  end
endmodule
